//--- itc_top.sv
// itc_top: two-line interrupt controller and 8-bit tick timer
// assumes channel and sync events are one-cycle pulses on ref_clk_i; pin is asynchronous
`timescale 1ns/100ps
`default_nettype none
module itc_top #(
    parameter int TICK_CYCLES = itc_pkg::ITC_TICK_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic irq_pin_n_i,
    input wire logic chan_two_wire_i,
    input wire logic chan_buf_empty_i,
    input wire logic chan_ack_fall_i,
    input wire logic chan_stop_i,
    input wire logic freq_ready_i,
    input wire logic freq_hv_i,
    input wire logic serial_event_i,
    input wire logic vec_fetch_i,
    output logic [15:0] vec_lo_addr_o,
    output logic [15:0] vec_hi_addr_o,
    output logic prio_request_o,
    output logic shared_request_o,
    output logic chan_soft_reset_o,
    output logic freq_is_horiz_o
);
    import itc_pkg::*;

    logic pin_irq_en_q;
    logic timer_irq_en_q;
    logic freq_irq_en_q;
    logic chan_irq_en_q;
    logic serial_irq_en_q;
    logic edge_sel_q;
    logic chan_soft_reset_q;
    logic pin_pending_q;
    logic timer_pending_q;
    logic freq_pending_q;
    logic chan_pending_q;
    logic serial_pending_q;
    logic timeout_flag_q;
    logic count_valid_q;
    logic freq_hv_q;
    logic [7:0] tick_count_q;
    logic [31:0] div_q;
    logic tick_en;
    itc_tstate_t tstate_q;
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_old_q;
    logic pin_low;
    logic pin_fall;
    logic wr_irq;
    logic wr_tick;
    logic rd_irq;
    logic rd_tick;
    logic rd_freq;
    logic wr_data;
    logic wr_stat;
    logic wr_ser;
    logic tick_zero_ev;
    logic [7:0] rdata_d;
    logic prio_d;
    logic shared_d;

    assign wr_irq = reg_wr_i && (reg_addr_i == ITC_OFS_IRQ);
    assign wr_tick = reg_wr_i && (reg_addr_i == ITC_OFS_TICK);
    assign wr_data = reg_wr_i && (reg_addr_i == ITC_OFS_CHAN_DATA);
    assign wr_stat = reg_wr_i && (reg_addr_i == ITC_OFS_CHAN_STAT);
    assign wr_ser = reg_wr_i && (reg_addr_i == ITC_OFS_SER_ADDR);
    assign rd_irq = reg_rd_i && (reg_addr_i == ITC_OFS_IRQ);
    assign rd_tick = reg_rd_i && (reg_addr_i == ITC_OFS_TICK);
    assign rd_freq = reg_rd_i && (reg_addr_i == ITC_OFS_FREQ);

    // flops reset high, the pin's idle level, so no false edge follows reset
    // pin crosses in through two flops; only the second is looked at
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_old_q <= 1'b1;
        end else begin
            pin_s1_q <= irq_pin_n_i;
            pin_s2_q <= pin_s1_q;
            pin_old_q <= pin_s2_q;
        end
    end
    assign pin_low = !pin_s2_q;
    assign pin_fall = pin_old_q && !pin_s2_q;

    // source enables
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_irq_en_q <= ITC_IRQ_RESET[ITC_BIT_PIN];
            timer_irq_en_q <= ITC_IRQ_RESET[ITC_BIT_TIMER];
            freq_irq_en_q <= ITC_IRQ_RESET[ITC_BIT_FREQ];
            chan_irq_en_q <= ITC_IRQ_RESET[ITC_BIT_CHAN];
            serial_irq_en_q <= ITC_IRQ_RESET[ITC_BIT_SER];
        end else if (wr_irq) begin
            pin_irq_en_q <= reg_wdata_i[ITC_BIT_PIN];
            timer_irq_en_q <= reg_wdata_i[ITC_BIT_TIMER];
            freq_irq_en_q <= reg_wdata_i[ITC_BIT_FREQ];
            chan_irq_en_q <= reg_wdata_i[ITC_BIT_CHAN];
            serial_irq_en_q <= reg_wdata_i[ITC_BIT_SER];
        end
    end

    // pin trigger select
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            edge_sel_q <= ITC_IRQ_RESET[ITC_BIT_EDGE];
        end else if (wr_irq) begin
            edge_sel_q <= reg_wdata_i[ITC_BIT_EDGE];
        end
    end

    // channel reset holds for as long as software leaves a one written
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chan_soft_reset_q <= ITC_IRQ_RESET[ITC_BIT_CRST];
        end else if (wr_irq) begin
            chan_soft_reset_q <= reg_wdata_i[ITC_BIT_CRST];
        end
    end

    // tick divider: one enable pulse per 1.024 ms
    // held at zero while idle so every load starts a full period
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= '0;
        end else if (wr_tick || tstate_q == ITC_T_IDLE) begin
            div_q <= '0;
        end else if (div_q == 32'(TICK_CYCLES - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 32'd1;
        end
    end
    assign tick_en = (tstate_q == ITC_T_RUN) && (div_q == 32'(TICK_CYCLES - 1));

    // tick timer: load, count down, stop at zero
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_count_q <= ITC_TICK_RESET;
            tstate_q <= ITC_T_IDLE;
        end else if (wr_tick) begin
            tick_count_q <= reg_wdata_i;
            tstate_q <= (reg_wdata_i == 8'h00) ? ITC_T_IDLE : ITC_T_RUN;
        end else begin
            case (tstate_q)
                ITC_T_RUN: begin
                    if (tick_en) begin
                        tick_count_q <= tick_count_q - 8'h01;
                        if (tick_count_q == 8'h01) begin
                            tstate_q <= ITC_T_IDLE;
                        end
                    end
                end
                default: begin
                    tstate_q <= ITC_T_IDLE;
                end
            endcase
        end
    end
    // a zero load times out at once rather than waiting a tick
    assign tick_zero_ev = (tick_en && tick_count_q == 8'h01) || (wr_tick && reg_wdata_i == 8'h00);

    // timeout flag: set beats the read that clears it
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timeout_flag_q <= 1'b0;
        end else if (tick_zero_ev) begin
            timeout_flag_q <= 1'b1;
        end else if (rd_tick) begin
            timeout_flag_q <= 1'b0;
        end
    end

    // sync count valid, cleared on frequency read; a new count beats the read
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_valid_q <= 1'b0;
        end else if (freq_ready_i) begin
            count_valid_q <= 1'b1;
        end else if (rd_freq) begin
            count_valid_q <= 1'b0;
        end
    end

    // h/v of the last valid count
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            freq_hv_q <= 1'b0;
        end else if (freq_ready_i) begin
            freq_hv_q <= freq_hv_i;
        end
    end

    // shared request pending flags, each sticky until its own clear
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_pending_q <= 1'b0;
        end else if (edge_sel_q ? pin_fall : pin_low) begin
            pin_pending_q <= 1'b1;
        end else if (rd_irq) begin
            pin_pending_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timer_pending_q <= 1'b0;
        end else if (tick_zero_ev) begin
            timer_pending_q <= 1'b1;
        end else if (rd_tick) begin
            timer_pending_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            freq_pending_q <= 1'b0;
        end else if (freq_ready_i) begin
            freq_pending_q <= 1'b1;
        end else if (rd_freq) begin
            freq_pending_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            serial_pending_q <= 1'b0;
        end else if (serial_event_i) begin
            serial_pending_q <= 1'b1;
        end else if (wr_ser) begin
            serial_pending_q <= 1'b0;
        end
    end

    // priority source; held clear while the channel is in soft reset
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chan_pending_q <= 1'b0;
        end else if (chan_soft_reset_q) begin
            chan_pending_q <= 1'b0;
        end else if (!chan_two_wire_i && chan_buf_empty_i) begin
            chan_pending_q <= 1'b1;
        end else if (chan_two_wire_i && (chan_ack_fall_i || chan_stop_i)) begin
            chan_pending_q <= 1'b1;
        end else if ((!chan_two_wire_i && wr_data) || (chan_two_wire_i && wr_stat)) begin
            chan_pending_q <= 1'b0;
        end
    end

    // request lines and vector addresses
    assign prio_d = chan_pending_q && chan_irq_en_q;
    assign shared_d = (pin_pending_q && pin_irq_en_q)
        || (timer_pending_q && timer_irq_en_q)
        || (freq_pending_q && freq_irq_en_q)
        || (serial_pending_q && serial_irq_en_q);
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prio_request_o <= 1'b0;
        end else begin
            prio_request_o <= prio_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shared_request_o <= 1'b0;
        end else begin
            shared_request_o <= shared_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chan_soft_reset_o <= 1'b0;
        end else begin
            chan_soft_reset_o <= chan_soft_reset_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            freq_is_horiz_o <= 1'b0;
        end else begin
            freq_is_horiz_o <= freq_hv_q;
        end
    end
    // vector latched at the fetch so it cannot change mid-fetch
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            vec_lo_addr_o <= ITC_VEC_SHARED_LO;
            vec_hi_addr_o <= ITC_VEC_SHARED_HI;
        end else if (vec_fetch_i) begin
            if (prio_d) begin
                vec_lo_addr_o <= ITC_VEC_PRIO_LO;
                vec_hi_addr_o <= ITC_VEC_PRIO_HI;
            end else begin
                vec_lo_addr_o <= ITC_VEC_SHARED_LO;
                vec_hi_addr_o <= ITC_VEC_SHARED_HI;
            end
        end
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    // enables are write-only; the read image shows flags and live status
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ITC_OFS_IRQ: begin
                    rdata_d[ITC_BIT_PIN] = pin_pending_q;
                    rdata_d[ITC_BIT_TIMER] = timer_pending_q;
                    rdata_d[ITC_BIT_FREQ] = freq_pending_q;
                    rdata_d[ITC_BIT_CHAN] = chan_pending_q;
                    rdata_d[ITC_BIT_EDGE] = pin_low;
                    rdata_d[ITC_BIT_TIMEOUT_FLAG] = timeout_flag_q;
                    rdata_d[ITC_BIT_VALID] = count_valid_q;
                    rdata_d[ITC_BIT_SER] = serial_pending_q;
                end
                ITC_OFS_TICK: begin
                    rdata_d = tick_count_q;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rdata_d;
        end
    end
endmodule
`default_nettype wire

//--- itc_pkg.sv
// itc_pkg: constants for the interrupt controller with tick timer
// assumes an 8-bit register port at byte offsets and a 40 MHz system clock
package itc_pkg;
    localparam logic [7:0] ITC_OFS_IRQ = 8'h1A;
    localparam logic [7:0] ITC_OFS_TICK = 8'h1B;
    localparam logic [7:0] ITC_OFS_CHAN_DATA = 8'h18;
    localparam logic [7:0] ITC_OFS_CHAN_STAT = 8'h19;
    localparam logic [7:0] ITC_OFS_FREQ = 8'h16;
    localparam logic [7:0] ITC_OFS_SER_ADDR = 8'h1E;
    localparam logic [15:0] ITC_VEC_PRIO_LO = 16'hFFFA;
    localparam logic [15:0] ITC_VEC_PRIO_HI = 16'hFFFB;
    localparam logic [15:0] ITC_VEC_SHARED_LO = 16'hFFFE;
    localparam logic [15:0] ITC_VEC_SHARED_HI = 16'hFFFF;
    localparam int ITC_BIT_PIN = 7;
    localparam int ITC_BIT_TIMER = 6;
    localparam int ITC_BIT_FREQ = 5;
    localparam int ITC_BIT_CHAN = 4;
    localparam int ITC_BIT_EDGE = 3;
    localparam int ITC_BIT_CRST = 2;
    localparam int ITC_BIT_TIMEOUT_FLAG = 2;
    localparam int ITC_BIT_VALID = 1;
    localparam int ITC_BIT_SER = 0;
    localparam logic [7:0] ITC_IRQ_RESET = 8'h00;
    localparam logic [7:0] ITC_TICK_RESET = 8'h00;
    localparam int ITC_CLK_HZ = 40000000;
    localparam int ITC_TICK_PERIOD_NS = 1024000;
    localparam int ITC_TICK_CYCLES = ITC_TICK_PERIOD_NS / (1000000000 / ITC_CLK_HZ);
    typedef enum logic [0:0] {
        ITC_T_IDLE = 1'b0,
        ITC_T_RUN = 1'b1
    } itc_tstate_t;
endpackage

//--- itc_checker.sv
// itc_checker: port assertions for itc_top
// assumes one clock and a low-active asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module itc_checker (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic chan_two_wire_i,
    input wire logic chan_buf_empty_i,
    input wire logic chan_ack_fall_i,
    input wire logic chan_stop_i,
    input wire logic freq_ready_i,
    input wire logic serial_event_i,
    input wire logic vec_fetch_i,
    input wire logic [15:0] vec_lo_addr_o,
    input wire logic [15:0] vec_hi_addr_o,
    input wire logic prio_request_o,
    input wire logic shared_request_o
);
    import itc_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // enables mirrored from bus writes, since the flags are not visible here
    logic [7:0] en_q;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_q <= 8'h00;
        end else if (reg_wr_i && reg_addr_i == ITC_OFS_IRQ) begin
            en_q <= reg_wdata_i;
        end
    end
    sequence s_quiet; !reg_wr_i && !reg_rd_i; endsequence
    property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_vec_prio; vec_fetch_i ##1 prio_request_o |-> vec_lo_addr_o == ITC_VEC_PRIO_LO
        && vec_hi_addr_o == ITC_VEC_PRIO_HI; endproperty
    a_vec_prio: assert property (p_vec_prio) else $error("bad priority vector");
    property p_vec_shr; vec_fetch_i ##1 !prio_request_o |-> vec_lo_addr_o == ITC_VEC_SHARED_LO
        && vec_hi_addr_o == ITC_VEC_SHARED_HI; endproperty
    a_vec_shr: assert property (p_vec_shr) else $error("bad shared vector");
    property p_prio_fall; $fell(prio_request_o) |-> $past(reg_wr_i, 2); endproperty
    a_prio_fall: assert property (p_prio_fall) else $error("priority dropped alone");
    property p_shr_fall; $fell(shared_request_o) |-> $past(reg_wr_i, 2) || $past(reg_rd_i, 2);
    endproperty
    a_shr_fall: assert property (p_shr_fall) else $error("shared dropped alone");
    property p_freq; freq_ready_i && en_q[5] && !reg_wr_i ##1 s_quiet |-> ##1 shared_request_o;
    endproperty
    a_freq: assert property (p_freq) else $error("no shared request on count");
    property p_ser; serial_event_i && en_q[0] && !reg_wr_i ##1 s_quiet |-> ##1 shared_request_o;
    endproperty
    a_ser: assert property (p_ser) else $error("no shared request on serial");
    property p_chan; !chan_two_wire_i && chan_buf_empty_i && en_q[4] && !en_q[2] && !reg_wr_i
        ##1 !reg_wr_i |-> ##1 prio_request_o; endproperty
    a_chan: assert property (p_chan) else $error("no priority on empty");
    property p_wire; chan_two_wire_i && (chan_ack_fall_i || chan_stop_i) && en_q[4] && !en_q[2]
        && !reg_wr_i ##1 !reg_wr_i |-> ##1 prio_request_o; endproperty
    a_wire: assert property (p_wire) else $error("no priority on ack or stop");
    c_prio: cover property (vec_fetch_i && prio_request_o);
    c_shr: cover property (vec_fetch_i && !prio_request_o && shared_request_o);
    c_both: cover property (prio_request_o && shared_request_o);
endmodule
bind itc_top itc_checker u_chk (.*);
`default_nettype wire

//--- itc_core_model.sv
// itc_core_model: processor core taking a vector fetch on request
// assumes one-cycle fetch pulse and vectors readable one edge later
`timescale 1ns/100ps
`default_nettype none
module itc_core_model (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic prio_i,
    input wire logic shared_i,
    input wire logic [15:0] lo_i,
    input wire logic [15:0] hi_i,
    input wire logic serve_i,
    input wire logic slow_i,
    output logic fetch_o,
    output logic got_o,
    output logic [31:0] vec_o
);
    // slow mode mimics a long instruction finishing before the fetch
    always @(posedge ref_clk_i) begin
        if (!arst_n_i) begin
            fetch_o <= 1'b0;
            got_o <= 1'b0;
            vec_o <= 32'h0;
        end else if (serve_i && (prio_i || shared_i)) begin
            repeat (slow_i ? 6 : 1) @(posedge ref_clk_i);
            fetch_o <= 1'b1;
            @(posedge ref_clk_i);
            fetch_o <= 1'b0;
            @(posedge ref_clk_i);
            vec_o <= {hi_i, lo_i};
            got_o <= 1'b1;
            @(posedge ref_clk_i);
            got_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- test_irq_ctrl_with_tick_timer.sv
// test_irq_ctrl_with_tick_timer: self-checking bench for itc_top
// assumes a shortened tick period; core model answers fetches
`timescale 1ns/100ps
`default_nettype none
module test_irq_ctrl_with_tick_timer;
    import itc_pkg::*;
    localparam int TICK = 8;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic irq_pin_n_i = 1'b1;
    logic chan_two_wire_i = 1'b0;
    logic freq_hv_i = 1'b0;
    logic [4:0] ev = 5'h00;
    wire chan_buf_empty_i = ev[0];
    wire chan_ack_fall_i = ev[1];
    wire chan_stop_i = ev[2];
    wire freq_ready_i = ev[3];
    wire serial_event_i = ev[4];
    logic [7:0] reg_rdata_o;
    logic [15:0] vec_lo_addr_o;
    logic [15:0] vec_hi_addr_o;
    logic vec_fetch_i, prio_request_o, shared_request_o, chan_soft_reset_o, freq_is_horiz_o;
    logic serve = 1'b0;
    logic slow = 1'b0;
    logic got, rd_seen = 1'b0, hv;
    logic [31:0] seen;
    logic [31:0] exp_q[$];
    logic [7:0] cnt;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 99;
    always #12.5 ref_clk_i = ~ref_clk_i;
    itc_top #(.TICK_CYCLES(TICK)) uut (.*);
    itc_core_model core (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .prio_i(prio_request_o),
        .shared_i(shared_request_o), .lo_i(vec_lo_addr_o), .hi_i(vec_hi_addr_o),
        .serve_i(serve), .slow_i(slow), .fetch_o(vec_fetch_i), .got_o(got), .vec_o(seen));
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 8'h00);
    endtask
    task automatic pulse(input int k);
        @(posedge ref_clk_i);
        ev <= 5'(1 << k);
        @(posedge ref_clk_i);
        ev <= 5'h00;
    endtask
    task automatic wait_for(input logic s, input logic v, input int lim);
        repeat (lim) begin
            if ((s ? shared_request_o : prio_request_o) === v) break;
            @(posedge ref_clk_i);
        end
        chk(s ? shared_request_o : prio_request_o, v, "request");
        if ((s ? shared_request_o : prio_request_o) !== v) close_out();
    endtask
    task automatic serve_chk(input logic [31:0] e, input logic s);
        exp_q.push_back(e);
        @(posedge ref_clk_i);
        slow <= s;
        serve <= 1'b1;
        @(posedge ref_clk_i);
        serve <= 1'b0;
        repeat (12) @(posedge ref_clk_i);
    endtask
    // results land one edge after they show, so compare in arrival order
    always @(posedge ref_clk_i) begin
        rd_seen <= reg_rd_i;
        if (rd_seen || got) begin
            if (exp_q.size() == 0) chk(32'h0, 32'h1, "queue");
            else chk(got ? seen : {24'h0, reg_rdata_o}, exp_q.pop_front(), "result");
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        rd(ITC_OFS_IRQ, ITC_IRQ_RESET);
        rd(ITC_OFS_TICK, ITC_TICK_RESET);
        rd(8'h05, 8'h00);
        cnt = 8'(2 + ($random(seed) & 3));
        wr(ITC_OFS_IRQ, 8'h40);
        wr(ITC_OFS_TICK, cnt);
        repeat ((cnt - 1) * TICK) @(posedge ref_clk_i);
        chk(shared_request_o, 1'b0, "early");
        wait_for(1'b1, 1'b1, 3 * TICK);
        rd(ITC_OFS_IRQ, 8'h44);
        rd(ITC_OFS_TICK, 8'h00);
        rd(ITC_OFS_IRQ, 8'h00);
        wait_for(1'b1, 1'b0, 4);
        hv = 1'($random(seed));
        freq_hv_i <= hv;
        wr(ITC_OFS_IRQ, 8'h20);
        pulse(3);
        wait_for(1'b1, 1'b1, 4);
        chk(freq_is_horiz_o, hv, "hv");
        rd(ITC_OFS_IRQ, 8'h22);
        rd(ITC_OFS_FREQ, 8'h00);
        wait_for(1'b1, 1'b0, 4);
        wr(ITC_OFS_IRQ, 8'h01);
        pulse(4);
        wait_for(1'b1, 1'b1, 4);
        wr(ITC_OFS_SER_ADDR, 8'h00);
        wait_for(1'b1, 1'b0, 4);
        for (int m = 0; m < 2; m++) begin
            wr(ITC_OFS_IRQ, m ? 8'h88 : 8'h80);
            irq_pin_n_i <= 1'b0;
            wait_for(1'b1, 1'b1, 8);
            rd(ITC_OFS_IRQ, 8'h88);
            rd(ITC_OFS_IRQ, m ? 8'h08 : 8'h88);
            irq_pin_n_i <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            rd(ITC_OFS_IRQ, m ? 8'h00 : 8'h80);
            rd(ITC_OFS_IRQ, 8'h00);
        end
        wr(ITC_OFS_IRQ, 8'h11);
        pulse(0);
        pulse(4);
        wait_for(1'b0, 1'b1, 4);
        serve_chk({ITC_VEC_PRIO_HI, ITC_VEC_PRIO_LO}, 1'b0);
        wr(ITC_OFS_CHAN_STAT, 8'h00);
        repeat (2) @(posedge ref_clk_i);
        chk(prio_request_o, 1'b1, "prio");
        wr(ITC_OFS_CHAN_DATA, 8'h00);
        wait_for(1'b0, 1'b0, 4);
        serve_chk({ITC_VEC_SHARED_HI, ITC_VEC_SHARED_LO}, 1'b1);
        wr(ITC_OFS_SER_ADDR, 8'h00);
        chan_two_wire_i <= 1'b1;
        for (int k = 1; k < 3; k++) begin
            pulse(k);
            wait_for(1'b0, 1'b1, 4);
            wr(ITC_OFS_CHAN_DATA, 8'h00);
            repeat (2) @(posedge ref_clk_i);
            chk(prio_request_o, 1'b1, "prio");
            wr(ITC_OFS_CHAN_STAT, 8'h00);
            wait_for(1'b0, 1'b0, 4);
        end
        wr(ITC_OFS_IRQ, 8'h14);
        repeat (2) @(posedge ref_clk_i);
        chk(chan_soft_reset_o, 1'b1, "chan reset");
        pulse(1);
        repeat (4) @(posedge ref_clk_i);
        chk(prio_request_o, 1'b0, "prio");
        wr(ITC_OFS_IRQ, 8'h10);
        repeat (2) @(posedge ref_clk_i);
        chk(chan_soft_reset_o, 1'b0, "chan reset");
        pulse(1);
        wait_for(1'b0, 1'b1, 4);
        repeat (4) @(posedge ref_clk_i);
        chk(exp_q.size(), 32'h0, "queue");
        close_out();
    end
endmodule
`default_nettype wire
